// *** gsa_status_top.sv ***
// general status byte aggregator top level
// Functional notes
// - bit 3 high only when all established standard connections run normally
// - unestablished standard connections ignored; any one error forces bit 3 low
// - dual network: bit 3 is AND of per-network standard status
// - bit 4 low with no safety connection or all normal
// - bit 4 set when any master or slave safety connection errs
// - master only: bit 5 high when all master connections normal and no slave error
// - master and slave: bit 5 needs all masters normal, no slave error
// - bit 6 high only in run mode
// - bit 7 high unless any defined error is active
// - bit 2 set on any standard error; dual network ORs both
// - bits 0 and 1 report input and output supply faults, low if unused
`timescale 1ns/1ps
`default_nettype none
module gsa_status_top #(
  parameter int unsigned NUM_STD_CONN  = 8,
  parameter int unsigned NUM_SAFE_MSTR = 8,
  parameter int unsigned NUM_ERR_SRC   = 16,
  parameter bit          DUAL_NETWORK  = 1'b1
) (
  input  wire logic                                                clk,
  input  wire logic                                                rst_n,
  input  wire logic [NUM_STD_CONN*gsa_pkg::CONN_STATE_WIDTH-1:0]   std_a_state,
  input  wire logic [NUM_STD_CONN-1:0]                             std_a_cfg,
  input  wire logic [NUM_STD_CONN*gsa_pkg::CONN_STATE_WIDTH-1:0]   std_b_state,
  input  wire logic [NUM_STD_CONN-1:0]                             std_b_cfg,
  input  wire logic [NUM_SAFE_MSTR*gsa_pkg::CONN_STATE_WIDTH-1:0]  safe_mstr_state,
  input  wire logic [NUM_SAFE_MSTR-1:0]                            safe_mstr_cfg,
  input  wire logic                                                safety_master_conn_error_code_a,
  input  wire logic                                                safety_master_conn_error_code_b,
  input  wire logic                                                safety_slave_conn_error_code,
  input  wire gsa_pkg::gsa_role_t                                  safety_role,
  input  wire gsa_pkg::gsa_mode_t                                  op_mode,
  input  wire logic [NUM_ERR_SRC-1:0]                              error_detail,
  input  wire logic                                                in_supply_fault,
  input  wire logic                                                out_supply_fault,
  input  wire logic                                                in_terminals_used,
  input  wire logic                                                out_terminals_used,
  output logic [gsa_pkg::STATUS_WIDTH-1:0]                         general_status_byte
);
  import gsa_pkg::*;

  // ==========================================================
  // connection summaries
  logic std_a_err;
  logic std_a_nrm;
  logic std_a_stp;
  logic std_b_err;
  logic std_b_nrm;
  logic std_b_stp;
  logic mstr_err;
  logic mstr_nrm;
  logic mstr_stp;

  gsa_conn_reduce #(.NUM_CONN(NUM_STD_CONN)) u_std_a (
    .conn_state  (std_a_state),
    .conn_cfg    (std_a_cfg),
    .any_error   (std_a_err),
    .any_normal  (std_a_nrm),
    .any_stopped (std_a_stp)
  );

  gsa_conn_reduce #(.NUM_CONN(NUM_STD_CONN)) u_std_b (
    .conn_state  (std_b_state),
    .conn_cfg    (std_b_cfg),
    .any_error   (std_b_err),
    .any_normal  (std_b_nrm),
    .any_stopped (std_b_stp)
  );

  gsa_conn_reduce #(.NUM_CONN(NUM_SAFE_MSTR)) u_safe_mstr (
    .conn_state  (safe_mstr_state),
    .conn_cfg    (safe_mstr_cfg),
    .any_error   (mstr_err),
    .any_normal  (mstr_nrm),
    .any_stopped (mstr_stp)
  );

  // ==========================================================
  // per-network standard status: at least one normal, none erring or stopped
  function automatic logic net_ok(input logic err, input logic nrm, input logic stp);
    net_ok = nrm && !err && !stp;
  endfunction

  // ==========================================================
  // synchronisers: supply monitors are asynchronous pins
  logic [1:0] in_sup_sync;
  logic [1:0] out_sup_sync;
  logic [1:0] next_in_sup_sync;
  logic [1:0] next_out_sup_sync;

  always_comb begin
    next_in_sup_sync  = {in_sup_sync[0], in_supply_fault};
    next_out_sup_sync = {out_sup_sync[0], out_supply_fault};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_sup_sync  <= 2'h0;
      out_sup_sync <= 2'h0;
    end else begin
      in_sup_sync  <= next_in_sup_sync;
      out_sup_sync <= next_out_sup_sync;
    end
  end

  // ==========================================================
  // status byte; rebuilt every cycle, there is no write path at all
  logic [STATUS_WIDTH-1:0] next_general_status_byte;
  logic                    net_a_ok;
  logic                    net_b_ok;
  logic                    safe_err;
  logic                    safe_ok;

  always_comb begin
    next_general_status_byte = STATUS_RESET;
    net_a_ok = net_ok(std_a_err, std_a_nrm, std_a_stp);
    net_b_ok = net_ok(std_b_err, std_b_nrm, std_b_stp);
    // a silent second network must not pull the AND down on single-network parts
    if (DUAL_NETWORK) begin
      next_general_status_byte[BIT_STD_COMM_OK] = net_a_ok && net_b_ok;
      next_general_status_byte[BIT_STD_COMM_ERROR] = std_a_err || std_b_err;
    end else begin
      next_general_status_byte[BIT_STD_COMM_OK] = net_a_ok;
      next_general_status_byte[BIT_STD_COMM_ERROR] = std_a_err;
    end
    safe_err = mstr_err || safety_master_conn_error_code_a
            || safety_master_conn_error_code_b || safety_slave_conn_error_code;
    next_general_status_byte[BIT_SAFE_COMM_ERROR] = safe_err;
    safe_ok = mstr_nrm && !mstr_err && !mstr_stp
           && !safety_master_conn_error_code_a && !safety_master_conn_error_code_b;
    case (safety_role)
      GSA_ROLE_MASTER: begin
        next_general_status_byte[BIT_SAFE_COMM_OK] = safe_ok && !safety_slave_conn_error_code;
      end
      GSA_ROLE_MASTER_SLAVE: begin
        next_general_status_byte[BIT_SAFE_COMM_OK] = safe_ok && !safety_slave_conn_error_code;
      end
      default: begin
        next_general_status_byte[BIT_SAFE_COMM_OK] = 1'b0;
      end
    endcase
    next_general_status_byte[BIT_RUN] = (op_mode == GSA_MODE_RUN);
    next_general_status_byte[BIT_NORMAL] = ~|error_detail;
    next_general_status_byte[BIT_IN_SUPPLY_FAULT] = in_sup_sync[1] && in_terminals_used;
    next_general_status_byte[BIT_OUT_SUPPLY_FAULT] = out_sup_sync[1] && out_terminals_used;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_status_byte <= STATUS_RESET;
    end else begin
      general_status_byte <= next_general_status_byte;
    end
  end
endmodule
`default_nettype wire

// *** gsa_pkg.sv ***
// package: constants for the general status flag aggregator
package gsa_pkg;
  // ==========================================================
  // status byte field positions
  localparam int unsigned BIT_IN_SUPPLY_FAULT  = 0;
  localparam int unsigned BIT_OUT_SUPPLY_FAULT = 1;
  localparam int unsigned BIT_STD_COMM_ERROR   = 2;
  localparam int unsigned BIT_STD_COMM_OK      = 3;
  localparam int unsigned BIT_SAFE_COMM_ERROR  = 4;
  localparam int unsigned BIT_SAFE_COMM_OK     = 5;
  localparam int unsigned BIT_RUN              = 6;
  localparam int unsigned BIT_NORMAL           = 7;
  localparam int unsigned STATUS_WIDTH         = 8;
  localparam logic [7:0]  STATUS_RESET         = 8'h00;
  // ==========================================================
  // per-connection communication state
  typedef enum logic [1:0] {
    GSA_CONN_IDLE,
    GSA_CONN_NORMAL,
    GSA_CONN_ERROR,
    GSA_CONN_STOPPED
  } gsa_conn_state_t;
  localparam int unsigned CONN_STATE_WIDTH = 2;
  // ==========================================================
  // operating modes of the controller
  typedef enum logic [1:0] {
    GSA_MODE_CONFIG,
    GSA_MODE_IDLE,
    GSA_MODE_RUN,
    GSA_MODE_ABORT
  } gsa_mode_t;
  // ==========================================================
  // safety roles
  typedef enum logic [1:0] {
    GSA_ROLE_NONE,
    GSA_ROLE_MASTER,
    GSA_ROLE_MASTER_SLAVE
  } gsa_role_t;
endpackage

// *** gsa_conn_reduce.sv ***
// connection reducer: folds per-connection states into summary flags
`timescale 1ns/1ps
`default_nettype none
module gsa_conn_reduce #(
  parameter int unsigned NUM_CONN = 8
) (
  input  wire logic [NUM_CONN*gsa_pkg::CONN_STATE_WIDTH-1:0] conn_state,
  input  wire logic [NUM_CONN-1:0]                           conn_cfg,
  output logic                                               any_error,
  output logic                                               any_normal,
  output logic                                               any_stopped
);
  import gsa_pkg::*;

  logic [NUM_CONN-1:0] err_vec;
  logic [NUM_CONN-1:0] nrm_vec;
  logic [NUM_CONN-1:0] stp_vec;

  // ==========================================================
  // per-connection classification; unconfigured slots are ignored
  genvar g;
  generate
    for (g = 0; g < NUM_CONN; g++) begin : g_conn
      logic [1:0] st;
      assign st         = conn_state[g*CONN_STATE_WIDTH +: CONN_STATE_WIDTH];
      assign err_vec[g] = conn_cfg[g] && (st == GSA_CONN_ERROR);
      assign nrm_vec[g] = conn_cfg[g] && (st == GSA_CONN_NORMAL);
      assign stp_vec[g] = conn_cfg[g] && (st == GSA_CONN_STOPPED);
    end
  endgenerate

  assign any_error   = |err_vec;
  assign any_normal  = |nrm_vec;
  assign any_stopped = |stp_vec;
endmodule
`default_nettype wire

// *** gsa_chk_assertions.sv ***
// checker: timing relations of the general status byte
`timescale 1ns/1ps
`default_nettype none
module gsa_chk #(parameter int unsigned N = 8, parameter int unsigned E = 16) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic [2*N-1:0]     std_a_state,
  input wire logic [N-1:0]       std_a_cfg,
  input wire logic               safety_master_conn_error_code_a,
  input wire logic               safety_master_conn_error_code_b,
  input wire logic               safety_slave_conn_error_code,
  input wire gsa_pkg::gsa_role_t safety_role,
  input wire gsa_pkg::gsa_mode_t op_mode,
  input wire logic [E-1:0]       error_detail,
  input wire logic               in_supply_fault,
  input wire logic               out_supply_fault,
  input wire logic               in_terminals_used,
  input wire logic               out_terminals_used,
  input wire logic [7:0]         general_status_byte
);
  import gsa_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [7:0] b = general_status_byte;
  wire se = std_a_cfg[0] && std_a_state[1:0] == 2'h2;
  wire sc = safety_master_conn_error_code_a || safety_master_conn_error_code_b || safety_slave_conn_error_code;
  // the byte is registered, so each check looks one edge later; attempts begun in reset are dropped
  // supply pins pass two synchronising flops before the byte register
  sequence s_in_fault_held;
    (in_supply_fault && in_terminals_used) [*3];
  endsequence
  sequence s_out_fault_held;
    (out_supply_fault && out_terminals_used) [*3];
  endsequence
  a_run_flag: assert property ((op_mode == GSA_MODE_RUN) |=> b[6]) else $error("run");
  a_run_low: assert property ((op_mode != GSA_MODE_RUN) |=> !b[6]) else $error("run low");
  a_normal_flag: assert property ((error_detail == '0) |=> b[7]) else $error("normal");
  a_normal_low: assert property ((error_detail != '0) |=> !b[7]) else $error("normal low");
  a_std_err: assert property (se |=> b[2]) else $error("std err");
  a_std_ok_low: assert property (se |=> !b[3]) else $error("std ok");
  a_safe_err: assert property (sc |=> b[4]) else $error("safe err");
  a_safe_ok: assert property ((sc || safety_role == GSA_ROLE_NONE) |=> !b[5]) else $error("ok");
  a_in_supply: assert property (!in_terminals_used |=> !b[0]) else $error("in supply");
  a_out_supply: assert property (!out_terminals_used |=> !b[1]) else $error("out supply");
  a_in_fault_seen: assert property (s_in_fault_held |=> b[0]) else $error("in fault");
  a_out_fault_seen: assert property (s_out_fault_held |=> b[1]) else $error("out fault");
endmodule
bind gsa_status_top gsa_chk #(
  .N (NUM_STD_CONN),
  .E (NUM_ERR_SRC)
) u_chk (
  .clk                             (clk),
  .rst_n                           (rst_n),
  .std_a_state                     (std_a_state),
  .std_a_cfg                       (std_a_cfg),
  .safety_master_conn_error_code_a (safety_master_conn_error_code_a),
  .safety_master_conn_error_code_b (safety_master_conn_error_code_b),
  .safety_slave_conn_error_code    (safety_slave_conn_error_code),
  .safety_role                     (safety_role),
  .op_mode                         (op_mode),
  .error_detail                    (error_detail),
  .in_supply_fault                 (in_supply_fault),
  .out_supply_fault                (out_supply_fault),
  .in_terminals_used               (in_terminals_used),
  .out_terminals_used              (out_terminals_used),
  .general_status_byte             (general_status_byte)
);
`default_nettype wire

// *** gsa_reader.sv ***
// partner: remote controller view of the status byte
`timescale 1ns/1ps
`default_nettype none
module gsa_reader (
  input  wire logic       link_up,
  input  wire logic [7:0] status_in,
  output logic      [7:0] seen
);
  assign seen = link_up ? status_in : 8'h00;
endmodule
`default_nettype wire

// *** tb_general_status_flag_aggregator.sv ***
// testbench: status byte scenarios seen through the remote reader
`timescale 1ns/1ps
`default_nettype none
module tb_general_status_flag_aggregator;
  import gsa_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, link_up = 1'b0;
  logic [3:0] ac, as, bc, bs, ms, rl, md, cd, ed, sp;
  logic [1:0] mc;
  logic [7:0] st, st1, seen;
  int err_count = 0, total_checks = 0;
  gsa_status_top #(.NUM_STD_CONN(2), .NUM_SAFE_MSTR(2), .NUM_ERR_SRC(4), .DUAL_NETWORK(1'b1)) dut (
    .clk(clk), .rst_n(rst_n), .std_a_state(as), .std_a_cfg(ac[1:0]), .std_b_state(bs), .std_b_cfg(bc[1:0]),
    .safe_mstr_state(ms), .safe_mstr_cfg(mc), .safety_master_conn_error_code_a(cd[2]),
    .safety_master_conn_error_code_b(cd[1]), .safety_slave_conn_error_code(cd[0]),
    .safety_role(gsa_role_t'(rl[1:0])), .op_mode(gsa_mode_t'(md[1:0])), .error_detail(ed),
    .in_supply_fault(sp[3]), .out_supply_fault(sp[2]), .in_terminals_used(sp[1]),
    .out_terminals_used(sp[0]), .general_status_byte(st));
  // single-network build on the same stimulus: network B must have no say there
  gsa_status_top #(.NUM_STD_CONN(2), .NUM_SAFE_MSTR(2), .NUM_ERR_SRC(4), .DUAL_NETWORK(1'b0)) dut_one (
    .clk(clk), .rst_n(rst_n), .std_a_state(as), .std_a_cfg(ac[1:0]), .std_b_state(bs), .std_b_cfg(bc[1:0]),
    .safe_mstr_state(ms), .safe_mstr_cfg(mc), .safety_master_conn_error_code_a(cd[2]),
    .safety_master_conn_error_code_b(cd[1]), .safety_slave_conn_error_code(cd[0]),
    .safety_role(gsa_role_t'(rl[1:0])), .op_mode(gsa_mode_t'(md[1:0])), .error_detail(ed),
    .in_supply_fault(sp[3]), .out_supply_fault(sp[2]), .in_terminals_used(sp[1]),
    .out_terminals_used(sp[0]), .general_status_byte(st1));
  gsa_reader rdr (.link_up(link_up), .status_in(st), .seen(seen));
  initial forever #10 clk = ~clk;
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    err_count += int'(got !== exp);
    if (got !== exp) $display("wrong value at %0t: got %h exp %h", $time, got, exp);
  endtask
  // fields: a cfg, a state, b cfg, b state, master state, role, mode, codes, errors, supply
  // e is the dual-network byte seen by the reader, e1 the single-network byte
  task automatic go(input logic [39:0] v, input logic [7:0] e, input logic [7:0] e1);
    {ac, as, bc, bs, ms, rl, md, cd, ed, sp} = v;
    repeat (4) @(negedge clk); // four edges also cover the synchronised supply bits
    cmp(seen, e);
    cmp(st1, e1);
  endtask
  initial begin
    {ac, as, bc, bs, ms, rl, md, cd, ed, sp} = 40'h0;
    mc = 2'h3;
    repeat (20) @(negedge clk);
    cmp(st, STATUS_RESET);
    cmp(st1, STATUS_RESET);
    rst_n = 1'b1;
    go(40'h0, 8'h00, 8'h80);
    cmp(st, 8'h80);
    link_up = 1'b1;
    go(40'h0000000000, 8'h80, 8'h80);
    go(40'h0000001000, 8'h80, 8'h80);
    go(40'h0000002000, 8'hC0, 8'hC0);
    go(40'h0000003000, 8'h80, 8'h80);
    go(40'h3100000000, 8'h80, 8'h88);
    go(40'h3111000000, 8'h88, 8'h88);
    go(40'h3113000000, 8'h80, 8'h88);
    go(40'h3611000000, 8'h84, 8'h84);
    go(40'h3112000000, 8'h84, 8'h88);
    go(40'h3111510000, 8'hA8, 8'hA8);
    go(40'h3111510400, 8'h98, 8'h98);
    go(40'h3111510100, 8'h98, 8'h98);
    go(40'h3111520000, 8'hA8, 8'hA8);
    go(40'h3111520100, 8'h98, 8'h98);
    go(40'h3111520200, 8'h98, 8'h98);
    go(40'h3111920000, 8'h98, 8'h98);
    mc = 2'h1;
    go(40'h3111910000, 8'hA8, 8'hA8);
    mc = 2'h3;
    go(40'h3111500000, 8'h88, 8'h88);
    go(40'h3111500010, 8'h08, 8'h08);
    go(40'h311150000C, 8'h88, 8'h88);
    go(40'h311150000A, 8'h89, 8'h89);
    go(40'h3111500005, 8'h8A, 8'h8A);
    go(40'h311150000F, 8'h8B, 8'h8B);
    rst_n = 1'b0;
    @(negedge clk);
    cmp(st, STATUS_RESET);
    cmp(st1, STATUS_RESET);
    rst_n = 1'b1;
    go(40'h311150000F, 8'h8B, 8'h8B);
    final_report();
  end
  // the sequence needs about 2.4 us, so this leaves a wide margin
  initial begin
    #20000 err_count++;
    final_report();
  end
endmodule
`default_nettype wire
